// ==== core/ssienc_frame.sv ====
// Converts the encoder position into a ready SSI frame word, refreshed
// continuously by a serial divider (one quotient bit per aclk).
// Assumes position and configuration come from logic on aclk.
`timescale 1ns/100ps
module ssienc_frame #(
  parameter int unsigned POS_W = 32
) (
  // Clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // Position and configuration
  input  wire logic [POS_W-1:0]                  enc_pos,
  input  wire logic [31:0]                       resolution,
  input  wire logic [4:0]                        singleturn_bit_count,
  input  wire logic [4:0]                        multiturn_bit_count,
  input  wire logic                              multiturn_en,
  input  wire logic                              gray_en,
  // Frame result, right aligned
  output logic [ssienc_pkg::SSIENC_FRAME_MAX-1:0] frame_word,
  output logic [ssienc_pkg::SSIENC_LEN_W-1:0]     frame_len
);
  import ssienc_pkg::*;

  logic [63:0] num_r, num_nxt;
  logic [32:0] rem_r, rem_nxt;
  logic [63:0] quo_r, quo_nxt;
  logic [6:0]  step_r, step_nxt;
  logic        neg_r, neg_nxt;
  logic [31:0] res_r, res_nxt;
  logic [6:0]  len_r, len_nxt;
  logic        gray_r, gray_nxt;
  logic [63:0] word_r, word_nxt;
  logic [6:0]  olen_r, olen_nxt;
  logic [32:0] rem_sh;
  logic [31:0] pos_abs;
  logic [63:0] value;
  logic [63:0] masked;
  logic [6:0]  st_len;
  logic [6:0]  mt_len;

  if (POS_W < 2 || POS_W > 32) begin : g_chk
    $error("ssienc_frame supports positions of 2 to 32 bits");
  end

  // Divider step, snapshot of configuration and final frame assembly
  always_comb begin
    num_nxt  = num_r;
    rem_nxt  = rem_r;
    quo_nxt  = quo_r;
    step_nxt = step_r;
    neg_nxt  = neg_r;
    res_nxt  = res_r;
    len_nxt  = len_r;
    gray_nxt = gray_r;
    word_nxt = word_r;
    olen_nxt = olen_r;
    st_len   = 7'({2'b00, singleturn_bit_count}) + 7'h01;  // RL3
    mt_len   = multiturn_en ? 7'({2'b00, multiturn_bit_count}) + 7'h01 : 7'h00;  // RL4 RL5
    pos_abs  = 32'(enc_pos[POS_W-1] ? -$signed(enc_pos) : $signed(enc_pos));
    rem_sh   = {rem_r[31:0], num_r[63]};
    value    = neg_r ? 64'(-(quo_r + 64'(rem_r != 33'h0))) : quo_r;  // RL6
    masked   = (len_r == 7'h40) ? value : value & ((64'h1 << len_r) - 64'h1);
    if (step_r == 7'h00) begin
      // Position scaled by 2^singleturn bits per revolution of resolution
      num_nxt  = {32'h0000_0000, pos_abs} << st_len;  // RL1 RL2
      rem_nxt  = 33'h0;
      quo_nxt  = 64'h0;
      neg_nxt  = enc_pos[POS_W-1];
      res_nxt  = resolution;
      len_nxt  = st_len + mt_len;  // RL6
      gray_nxt = gray_en;
      step_nxt = 7'h01;
    end else if (step_r == 7'h41) begin
      // Quotient done: its low bits are revolutions then angle
      word_nxt = (res_r == 32'h0) ? 64'h0 : (gray_r ? masked ^ (masked >> 1) : masked);  // RL12
      olen_nxt = len_r;
      step_nxt = 7'h00;
    end else begin
      num_nxt  = {num_r[62:0], 1'b0};
      if (rem_sh >= {1'b0, res_r}) begin
        rem_nxt = rem_sh - {1'b0, res_r};
        quo_nxt = {quo_r[62:0], 1'b1};
      end else begin
        rem_nxt = rem_sh;
        quo_nxt = {quo_r[62:0], 1'b0};
      end
      step_nxt = step_r + 7'h01;
    end
  end

  // Divider and result registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      num_r  <= 64'h0;
      rem_r  <= 33'h0;
      quo_r  <= 64'h0;
      step_r <= 7'h00;
      neg_r  <= 1'b0;
      res_r  <= 32'h0;
      len_r  <= 7'h01;
      gray_r <= 1'b0;
      word_r <= 64'h0;
      olen_r <= 7'h01;
    end else begin
      num_r  <= num_nxt;
      rem_r  <= rem_nxt;
      quo_r  <= quo_nxt;
      step_r <= step_nxt;
      neg_r  <= neg_nxt;
      res_r  <= res_nxt;
      len_r  <= len_nxt;
      gray_r <= gray_nxt;
      word_r <= word_nxt;
      olen_r <= olen_nxt;
    end
  end

  assign frame_word = word_r;
  assign frame_len  = olen_r;

endmodule : ssienc_frame

// ==== core/ssienc_pkg.sv ====
// Shared constants for the SSI encoder output block: register indices,
// field positions, reset values, bus responses and the serial state type.
// Assumes a 32-bit AXI4-Lite register bus with one word per register index.
package ssienc_pkg;

  // Register bus geometry
  localparam int unsigned SSIENC_ADDR_W = 9;
  localparam int unsigned SSIENC_DATA_W = 32;
  localparam int unsigned SSIENC_IDX_W  = 7;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_GENERAL_CONFIGURATION       = 7'h00;
  localparam logic [6:0] IDX_SSI_HOLD_TIME               = 7'h04;
  localparam logic [6:0] IDX_ENCODER_INPUT_CONFIGURATION = 7'h07;
  localparam logic [6:0] IDX_OUTPUT_FRAME_STRUCTURE      = 7'h09;
  localparam logic [6:0] IDX_OUTPUT_RESOLUTION           = 7'h55;
  localparam logic [6:0] IDX_SSI_STATUS                  = 7'h56;
  localparam logic [6:0] IDX_HELD_FRAME_LOW              = 7'h57;
  localparam logic [6:0] IDX_HELD_FRAME_HIGH             = 7'h58;

  // Reset values
  localparam logic [31:0] GENERAL_CONFIGURATION_RST       = 32'h0000_6020;
  localparam logic [31:0] SSI_HOLD_TIME_RST               = 32'h0000_0000;
  localparam logic [31:0] ENCODER_INPUT_CONFIGURATION_RST = 32'h0000_0000;
  localparam logic [31:0] OUTPUT_FRAME_STRUCTURE_RST      = 32'h0000_0000;
  localparam logic [31:0] OUTPUT_RESOLUTION_RST           = 32'h0000_0000;

  // Field positions
  localparam int unsigned GC_SERIAL_OUT_EN_BIT = 24;
  localparam int unsigned GC_DIFF_DISABLE_BIT  = 25;
  localparam int unsigned EIC_MULTITURN_EN_BIT = 14;
  localparam int unsigned EIC_GRAY_OUT_BIT     = 30;
  localparam int unsigned FS_SINGLETURN_LSB    = 0;
  localparam int unsigned FS_SINGLETURN_MSB    = 4;
  localparam int unsigned FS_MULTITURN_LSB     = 5;
  localparam int unsigned FS_MULTITURN_MSB     = 9;
  localparam int unsigned HT_MONOFLOP_LSB      = 4;
  localparam int unsigned HT_MONOFLOP_MSB      = 24;

  // Frame geometry
  localparam int unsigned SSIENC_FRAME_MAX = 64;
  localparam int unsigned SSIENC_LEN_W     = 7;
  localparam int unsigned SSIENC_HOLD_W    = 21;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial output state
  typedef enum logic [0:0] {
    SSIENC_IDLE   = 1'b0,
    SSIENC_ACTIVE = 1'b1
  } ssienc_state_t;

endpackage : ssienc_pkg

// ==== core/ssienc_sync.sv ====
// Two-stage synchroniser for a group of level inputs from outside aclk.
// Assumes the inputs are plain levels; the first stage feeds only the second.
`timescale 1ns/100ps
module ssienc_sync #(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import ssienc_pkg::*;

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage1_nxt;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage2_nxt;

  if (W < 1) begin : g_chk
    $error("ssienc_sync needs at least one bit");
  end

  // Next values of both stages
  always_comb begin
    stage1_nxt = async_in;
    stage2_nxt = stage1_r;
  end

  // Stages reset to the idle high level of an SSI line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_r <= '1;
      stage2_r <= '1;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign sync_out = stage2_r;

endmodule : ssienc_sync

// ==== core/ssienc_top.sv ====
// SSI encoder output: AXI4-Lite register slave, frame builder and the
// serial shifter driven by an external SSI master clock pair.
// Assumes enc_pos is on aclk; SSI clock pins are asynchronous to aclk.
//
// Contract
// RL1: Outgoing data is formed from the encoder position value.
// RL2: Write-only resolution register scales position into the singleturn angle.
// RL3: Singleturn bits sent equal bit count field bits 4:0 plus one.
// RL4: Multiturn bits sent equal field bits 9:5 plus one when enabled.
// RL5: Multiturn is sent only when enable bit 14 is set.
// RL6: Signed revolution count precedes singleturn bits in one continuous frame.
// RL7: Data held unchanged until monoflop cycles pass after last master clock.
// RL8: Bit 24 of general configuration enables the serial data stream.
// RL9: Master drives clock pair in; device drives data pair out.
// RL10: Master supplies a differential clock pair in normal operation.
// RL11: Bit 25 makes signals single ended; negated pins are ignored.
// RL12: Bit 30 Gray-encodes the transmitted frame.
// RL13: Frame goes out MSB first, one bit per master clock, multiturn first.
// RL14: Master idles longer than monoflop time to get a fresh sample.
`timescale 1ns/100ps
module ssienc_top
  import ssienc_pkg::*;
#(
  parameter int unsigned POS_W = 32
) (
  // Clock and reset
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ssienc_pkg::SSIENC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ssienc_pkg::SSIENC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // Internal encoder position
  input  wire logic [POS_W-1:0]                    enc_pos,
  // SSI pins
  input  wire logic                                clock_in_pos,
  input  wire logic                                clock_in_neg,
  output logic                                     data_out_pos,
  output logic                                     data_out_neg
);

  // Configuration registers
  logic [31:0] gen_cfg_r, gen_cfg_nxt;
  logic [31:0] hold_time_r, hold_time_nxt;
  logic [31:0] enc_in_cfg_r, enc_in_cfg_nxt;
  logic [31:0] frame_struct_r, frame_struct_nxt;
  logic [31:0] out_res_r, out_res_nxt;
  // Write channel state
  logic        aw_full_r, aw_full_nxt;
  logic [6:0]  aw_idx_r, aw_idx_nxt;
  logic        aw_bad_r, aw_bad_nxt;
  logic        w_full_r, w_full_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  // Read channel state
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  // Serial state
  ssienc_state_t state_r, state_nxt;
  logic        sclk_r, sclk_nxt;
  logic        dout_r, dout_nxt;
  logic [63:0] shift_r, shift_nxt;
  logic [63:0] held_r, held_nxt;
  logic [6:0]  held_len_r, held_len_nxt;
  logic [6:0]  bits_left_r, bits_left_nxt;
  logic [20:0] mono_r, mono_nxt;
  // Combinational helpers
  logic        do_write;
  logic [1:0]  pins_s;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        out_en;
  logic        diff_dis;
  logic [63:0] frame_word;
  logic [6:0]  frame_len;
  logic [6:0]  ar_idx;

  if (POS_W < 2 || POS_W > 32) begin : g_chk
    $error("ssienc_top supports positions of 2 to 32 bits");
  end

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  assign out_en   = gen_cfg_r[GC_SERIAL_OUT_EN_BIT];
  assign diff_dis = gen_cfg_r[GC_DIFF_DISABLE_BIT];
  assign do_write = aw_full_r && w_full_r && !bvalid_r;
  assign ar_idx   = s_axi_araddr[8:2];

  // Write channel: address and data taken in either order
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_idx_nxt  = aw_idx_r;
    aw_bad_nxt  = aw_bad_r;
    w_full_nxt  = w_full_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_nxt = 1'b1;
      aw_idx_nxt  = s_axi_awaddr[8:2];
      aw_bad_nxt  = (s_axi_awaddr[1:0] != 2'h0);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_SLVERR;
      if (!aw_bad_r) begin
        case (aw_idx_r)
          IDX_GENERAL_CONFIGURATION,
          IDX_SSI_HOLD_TIME,
          IDX_ENCODER_INPUT_CONFIGURATION,
          IDX_OUTPUT_FRAME_STRUCTURE,
          IDX_OUTPUT_RESOLUTION,
          IDX_SSI_STATUS,
          IDX_HELD_FRAME_LOW,
          IDX_HELD_FRAME_HIGH: bresp_nxt = RESP_OKAY;
          default:             bresp_nxt = RESP_SLVERR;
        endcase
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // Register file updates on a completed write
  always_comb begin
    gen_cfg_nxt      = gen_cfg_r;
    hold_time_nxt    = hold_time_r;
    enc_in_cfg_nxt   = enc_in_cfg_r;
    frame_struct_nxt = frame_struct_r;
    out_res_nxt      = out_res_r;
    if (do_write && !aw_bad_r) begin
      case (aw_idx_r)
        IDX_GENERAL_CONFIGURATION:       gen_cfg_nxt = merge(gen_cfg_r, wdata_r, wstrb_r);
        IDX_SSI_HOLD_TIME:               hold_time_nxt = merge(hold_time_r, wdata_r, wstrb_r);
        IDX_ENCODER_INPUT_CONFIGURATION: enc_in_cfg_nxt = merge(enc_in_cfg_r, wdata_r, wstrb_r);
        IDX_OUTPUT_FRAME_STRUCTURE:      frame_struct_nxt = merge(frame_struct_r, wdata_r, wstrb_r);
        IDX_OUTPUT_RESOLUTION:           out_res_nxt = merge(out_res_r, wdata_r, wstrb_r);  // RL2
        default:                         ;
      endcase
    end
  end

  // Read channel: one cycle from address to data
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (s_axi_araddr[1:0] != 2'h0) begin
        rresp_nxt = RESP_SLVERR;
      end else begin
        case (ar_idx)
          IDX_GENERAL_CONFIGURATION:       rdata_nxt = gen_cfg_r;
          IDX_SSI_HOLD_TIME:               rdata_nxt = hold_time_r;
          IDX_ENCODER_INPUT_CONFIGURATION: rdata_nxt = enc_in_cfg_r;
          IDX_OUTPUT_FRAME_STRUCTURE:      rdata_nxt = frame_struct_r;
          IDX_OUTPUT_RESOLUTION:           rdata_nxt = 32'h0000_0000;
          IDX_SSI_STATUS:                  rdata_nxt = {17'h0, held_len_r, bits_left_r, state_r};
          IDX_HELD_FRAME_LOW:              rdata_nxt = held_r[31:0];
          IDX_HELD_FRAME_HIGH:             rdata_nxt = held_r[63:32];
          default:                         rresp_nxt = RESP_SLVERR;
        endcase
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bus and register flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_cfg_r      <= GENERAL_CONFIGURATION_RST;
      hold_time_r    <= SSI_HOLD_TIME_RST;
      enc_in_cfg_r   <= ENCODER_INPUT_CONFIGURATION_RST;
      frame_struct_r <= OUTPUT_FRAME_STRUCTURE_RST;
      out_res_r      <= OUTPUT_RESOLUTION_RST;
      aw_full_r      <= 1'b0;
      aw_idx_r       <= 7'h00;
      aw_bad_r       <= 1'b0;
      w_full_r       <= 1'b0;
      wdata_r        <= 32'h0000_0000;
      wstrb_r        <= 4'h0;
      bvalid_r       <= 1'b0;
      bresp_r        <= RESP_OKAY;
      rvalid_r       <= 1'b0;
      rdata_r        <= 32'h0000_0000;
      rresp_r        <= RESP_OKAY;
    end else begin
      gen_cfg_r      <= gen_cfg_nxt;
      hold_time_r    <= hold_time_nxt;
      enc_in_cfg_r   <= enc_in_cfg_nxt;
      frame_struct_r <= frame_struct_nxt;
      out_res_r      <= out_res_nxt;
      aw_full_r      <= aw_full_nxt;
      aw_idx_r       <= aw_idx_nxt;
      aw_bad_r       <= aw_bad_nxt;
      w_full_r       <= w_full_nxt;
      wdata_r        <= wdata_nxt;
      wstrb_r        <= wstrb_nxt;
      bvalid_r       <= bvalid_nxt;
      bresp_r        <= bresp_nxt;
      rvalid_r       <= rvalid_nxt;
      rdata_r        <= rdata_nxt;
      rresp_r        <= rresp_nxt;
    end
  end

  // Handshake outputs
  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready  = !w_full_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Clock pair into aclk
  ssienc_sync #(
    .W (2)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({clock_in_neg, clock_in_pos}),  // RL9 RL10
    .sync_out (pins_s)
  );

  // Frame builder
  ssienc_frame #(
    .POS_W (POS_W)
  ) u_frame (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .enc_pos              (enc_pos),
    .resolution           (out_res_r),
    .singleturn_bit_count (frame_struct_r[FS_SINGLETURN_MSB:FS_SINGLETURN_LSB]),
    .multiturn_bit_count  (frame_struct_r[FS_MULTITURN_MSB:FS_MULTITURN_LSB]),
    .multiturn_en         (enc_in_cfg_r[EIC_MULTITURN_EN_BIT]),
    .gray_en              (enc_in_cfg_r[EIC_GRAY_OUT_BIT]),
    .frame_word           (frame_word),
    .frame_len            (frame_len)
  );

  // Differential pair only counts when the two lines disagree
  assign sclk_nxt  = diff_dis ? pins_s[0]  // RL11
                   : ((pins_s[0] != pins_s[1]) ? pins_s[0] : sclk_r);
  assign sclk_fall = sclk_r && !sclk_nxt;
  assign sclk_rise = !sclk_r && sclk_nxt;

  // Serial shifter: fall latches or restarts, rise presents the next bit
  always_comb begin
    state_nxt     = state_r;
    dout_nxt      = dout_r;
    shift_nxt     = shift_r;
    held_nxt      = held_r;
    held_len_nxt  = held_len_r;
    bits_left_nxt = bits_left_r;
    mono_nxt      = mono_r;
    case (state_r)
      SSIENC_IDLE: begin
        dout_nxt = 1'b1;
        if (out_en && sclk_fall) begin  // RL8
          held_nxt      = frame_word;  // RL1
          held_len_nxt  = frame_len;
          shift_nxt     = frame_word << (7'h40 - frame_len);  // RL13
          bits_left_nxt = frame_len;
          mono_nxt      = hold_time_r[HT_MONOFLOP_MSB:HT_MONOFLOP_LSB];
          state_nxt     = SSIENC_ACTIVE;
        end
      end
      SSIENC_ACTIVE: begin
        if (!out_en) begin
          state_nxt = SSIENC_IDLE;
          dout_nxt  = 1'b1;
        end else if (sclk_fall || sclk_rise) begin
          // Every master edge restarts the monoflop
          mono_nxt = hold_time_r[HT_MONOFLOP_MSB:HT_MONOFLOP_LSB];  // RL7
          if (sclk_rise && bits_left_r == 7'h00) begin
            // Trailing rise sends 0 and rearms the held frame for a repeat
            shift_nxt     = held_r << (7'h40 - held_len_r);  // RL7
            bits_left_nxt = held_len_r;
          end
          if (sclk_rise) begin
            if (bits_left_r != 7'h00) begin
              dout_nxt      = shift_r[63];  // RL13 RL6
              shift_nxt     = {shift_r[62:0], 1'b0};
              bits_left_nxt = bits_left_r - 7'h01;
            end else begin
              dout_nxt = 1'b0;
            end
          end
        end else if (mono_r == 21'h0) begin
          state_nxt = SSIENC_IDLE;  // RL14
          dout_nxt  = 1'b1;
        end else begin
          mono_nxt = mono_r - 21'h1;
        end
      end
      default: begin
        state_nxt = SSIENC_IDLE;
        dout_nxt  = 1'b1;
      end
    endcase
  end

  // Serial flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= SSIENC_IDLE;
      sclk_r      <= 1'b1;
      dout_r      <= 1'b1;
      shift_r     <= 64'h0;
      held_r      <= 64'h0;
      held_len_r  <= 7'h01;
      bits_left_r <= 7'h00;
      mono_r      <= 21'h0;
    end else begin
      state_r     <= state_nxt;
      sclk_r      <= sclk_nxt;
      dout_r      <= dout_nxt;
      shift_r     <= shift_nxt;
      held_r      <= held_nxt;
      held_len_r  <= held_len_nxt;
      bits_left_r <= bits_left_nxt;
      mono_r      <= mono_nxt;
    end
  end

  // Data pair; negated line held low in single-ended mode
  assign data_out_pos = dout_r;  // RL9
  assign data_out_neg = diff_dis ? 1'b0 : !dout_r;  // RL11

endmodule : ssienc_top

// ==== verif/ssienc_checker.sv ====
// Port assertions for the SSI encoder output block.
// Assumes it is bound into ssienc_top and sees only its ports.
`timescale 1ns/100ps
module ssienc_checker (
  // Clock, reset and bus handshakes
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Link pins
  input wire logic clock_in_pos,
  input wire logic data_out_pos,
  input wire logic data_out_neg
);
  logic [3:0] age_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since the raw link clock rose, saturating
  always_ff @(posedge aclk)
    age_r <= !aresetn ? 4'hF : $rose(clock_in_pos) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
  a_bit_launch: assert property ($fell(data_out_pos) |-> age_r <= 4'h6)
    else $error("late bit");
  a_bit_hold: assert property ($rose(data_out_pos) |-> age_r >= 4'h2)
    else $error("early bit");
  a_neg_pair: assert property (data_out_neg |-> !data_out_pos)
    else $error("negated data");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write block");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read block");
  a_reset_idle: assert property ($rose(aresetn) |-> data_out_pos && !s_axi_bvalid)
    else $error("reset idle");
endmodule : ssienc_checker
bind ssienc_top ssienc_checker i_chk (.*);

// ==== verif/ssienc_master.sv ====
// SSI master model: drives the link clock pair, reads one frame per call.
// Assumes the bench idles past the hold time where it wants fresh data.
`timescale 1ns/100ps
module ssienc_master (
  // Link pins and mode
  output logic      clock_in_pos,
  output logic      clock_in_neg,
  input  wire logic data_out_pos,
  input  wire logic single_ended
);
  logic clk_r = 1'h1;
  // Clock idles high; negated clock parked high when single ended
  assign clock_in_pos = clk_r;
  assign clock_in_neg = single_ended ? 1'h1 : !clk_r;
  // 160 ns period; each bit is taken just before the next rise
  task automatic rd_frame(input int n, output logic [63:0] w);
    w = 64'h0;
    #7 clk_r = 1'h0;
    #80 clk_r = 1'h1;
    for (int i = 0; i < n; i++) begin
      #80 clk_r = 1'h0;
      #80 w = {w[62:0], data_out_pos};
      clk_r = 1'h1;
    end
  endtask : rd_frame
endmodule : ssienc_master

// ==== verif/tb.sv ====
// Bench for the SSI encoder output block over the bus and the link.
// Assumes ssienc_master on the link; the checker binds itself.
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
  import ssienc_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, single_ended = 1'h0, s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, clock_in_pos, clock_in_neg;
  logic        data_out_pos, data_out_neg;
  logic [8:0]  s_axi_awaddr = 9'h000, s_axi_araddr = 9'h000;
  logic [31:0] s_axi_wdata = 32'h0, enc_pos = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [63:0] w;
  int          err_count = 0, samples_checked = 0;
  localparam logic [31:0] P1 = 32'hFFFF_EC78, P2 = 32'h0000_3A5C;
  initial forever #10 aclk = ~aclk;
  // Design and link master
  ssienc_top i_dut (.*, .s_axi_wstrb(4'hF));
  ssienc_master i_mst (.*);
  // Counts and verdict; to marks a wait that ran out
  task automatic results(input bit to);
    err_count += to;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // One bus access held until its answer, then compared
  task automatic acc(input bit we, input logic [8:0] a, input logic [31:0] v,
                     input logic [1:0] er, input logic [31:0] ed);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {we, we, we, !we, !we};
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    `CHK("resp", er, (we ? s_axi_bresp : s_axi_rresp))
    if (!we) `CHK("rdata", ed, s_axi_rdata)
    if (n == 40) results(1'h1);
  endtask : acc
  // Expected frame: 7 angle bits at 4096 counts, optional 5 signed turns, optional Gray
  function automatic logic [63:0] ef(input logic [31:0] p, input bit mt, input bit gr);
    longint s;
    logic [63:0] v;
    s = longint'(signed'(p)) <<< 7;
    v = 64'(s >>> 12) & ((64'h1 << (mt ? 12 : 7)) - 64'h1);
    return gr ? v ^ (v >> 1) : v;
  endfunction : ef
  // Idle wt cycles, read an n-bit frame and compare it
  task automatic fr(input int wt, input int n, input logic [63:0] e);
    repeat (wt) @(posedge aclk);
    i_mst.rd_frame(n, w);
    `CHK("frame", e, w)
    @(posedge aclk);
  endtask : fr
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    acc(1'h0, 9'h000, 32'h0, RESP_OKAY, GENERAL_CONFIGURATION_RST);
    acc(1'h0, 9'h154, 32'h0, RESP_OKAY, 32'h0);
    acc(1'h0, 9'h1FC, 32'h0, RESP_SLVERR, 32'h0);
    acc(1'h1, 9'h1FC, 32'h1, RESP_SLVERR, 32'h0);
    $display("regs done");
    acc(1'h1, 9'h154, 32'h0000_1000, RESP_OKAY, 32'h0);
    acc(1'h1, 9'h010, 32'h0000_0100, RESP_OKAY, 32'h0);
    acc(1'h1, 9'h024, 32'h0000_0086, RESP_OKAY, 32'h0);
    acc(1'h1, 9'h01C, 32'h0000_4000, RESP_OKAY, 32'h0);
    acc(1'h1, 9'h000, 32'h0100_6020, RESP_OKAY, 32'h0);
    enc_pos <= P1;
    fr(150, 12, ef(P1, 1'h1, 1'h0));
    enc_pos <= P2;
    fr(4, 12, ef(P1, 1'h1, 1'h0));
    fr(200, 12, ef(P2, 1'h1, 1'h0));
    `CHK("neg", ~data_out_pos, data_out_neg)
    $display("multiturn done");
    acc(1'h1, 9'h01C, 32'h4000_0000, RESP_OKAY, 32'h0);
    fr(150, 7, ef(P2, 1'h0, 1'h1));
    acc(1'h1, 9'h000, 32'h0300_6020, RESP_OKAY, 32'h0);
    single_ended <= 1'h1;
    fr(150, 7, ef(P2, 1'h0, 1'h1));
    `CHK("neg", 1'h0, data_out_neg)
    acc(1'h1, 9'h000, 32'h0000_6020, RESP_OKAY, 32'h0);
    single_ended <= 1'h0;
    fr(150, 7, 64'h7F);
    $display("modes done");
    results(1'h0);
  end
endmodule : tb
